// ---- rtl/drive_status_params.svh ----
/*
 Selector constants: codes, offsets, reset values, timing.
 Assumes inclusion by bare name.
*/
`ifndef DRIVE_STATUS_PARAMS_SVH
`define DRIVE_STATUS_PARAMS_SVH

// Function codes, active-high form
`define CODE_RUNNING 11'h000
`define CODE_UNDERVOLT 11'h003
`define CODE_TORQUE_POL 11'h004
`define CODE_LIMITING 11'h005
`define CODE_KEYPAD 11'h008
`define CODE_READY 11'h00A
`define CODE_CONTACTOR 11'h00F
`define CODE_LIMIT_DLY 11'h016
`define CODE_UNIVERSAL 11'h01B
`define CODE_OVERHEAT 11'h01C
`define CODE_OUTPUT_ON 11'h023
`define CODE_PID 11'h02B
`define CODE_FORWARD 11'h034
`define CODE_REVERSE 11'h035
`define CODE_REMOTE 11'h036
`define CODE_CI_BREAK 11'h03B
`define CODE_SPEED_VALID 11'h046
`define CODE_ALARM_B0 11'h05A
`define CODE_ALARM_B1 11'h05B
`define CODE_ALARM_B2 11'h05C
`define CODE_ALARM_B3 11'h05D
`define CODE_ANY_ALARM 11'h063
`define CODE_CUSTOM_1 11'h06F
`define CODE_CUSTOM_5 11'h073
// Offset added to a code for inverted polarity
`define CODE_INVERT_OFS 11'h3E8

// Register byte offsets
`define REG_CODE_T0 8'h00
`define REG_CODE_T1 8'h04
`define REG_CODE_T2 8'h08
`define REG_CONTROL 8'h0C
`define REG_STATUS 8'h10
`define REG_CONDITIONS 8'h14
// Field positions
`define CTRL_UNIVERSAL_BIT 0
`define STAT_REFUSED_BIT 3

// Reset values of the code registers
`define RST_CODE_T0 11'h000
`define RST_CODE_T1 11'h00A
`define RST_CODE_T2 11'h063

// Timing: clock rate and times in milliseconds
`define CLK_HZ 125000000
`define MS_PER_S 1000
`define LIMIT_MIN_MS 8'h64
`define LIMIT_DELAY_MS 8'h14
`define SPEED_HOLD_MS 8'h64
// Heatsink warning margins in degrees C
`define OH_SET_MARGIN 9'h005
`define OH_CLR_MARGIN 9'h008

`endif

// ---- rtl/drive_status_pkg.sv ----
/*
 Selector types: condition indices and the code lookup.
 Assumes the constants header is on the include path.
*/
`include "drive_status_params.svh"

package drive_status_pkg;

   // Index of each internal condition in the condition vector
   typedef enum logic [4:0] {
      COND_RUNNING, COND_UNDERVOLT, COND_TORQUE_POL, COND_LIMITING,
      COND_KEYPAD, COND_READY, COND_CONTACTOR, COND_LIMIT_DLY,
      COND_UNIVERSAL, COND_OVERHEAT, COND_OUTPUT_ON, COND_PID,
      COND_FORWARD, COND_REVERSE, COND_REMOTE, COND_CI_BREAK,
      COND_SPEED_VALID, COND_ALARM_B0, COND_ALARM_B1, COND_ALARM_B2,
      COND_ALARM_B3, COND_ANY_ALARM, COND_CUSTOM_1, COND_CUSTOM_2,
      COND_CUSTOM_3, COND_CUSTOM_4, COND_CUSTOM_5
   } cond_e;

   // Width of the condition vector
   localparam int unsigned COND_N = 27;

   // Function code type
   typedef logic [10:0] func_code_t;

   // Maps a base code to {known, index}; unknown codes give zero
   function automatic logic [5:0] code_lookup(input func_code_t base);
      logic [5:0] r;
      r = 6'h00;
      case (base)
         `CODE_RUNNING: r = {1'b1, COND_RUNNING};
         `CODE_UNDERVOLT: r = {1'b1, COND_UNDERVOLT};
         `CODE_TORQUE_POL: r = {1'b1, COND_TORQUE_POL};
         `CODE_LIMITING: r = {1'b1, COND_LIMITING};
         `CODE_KEYPAD: r = {1'b1, COND_KEYPAD};
         `CODE_READY: r = {1'b1, COND_READY};
         `CODE_CONTACTOR: r = {1'b1, COND_CONTACTOR};
         `CODE_LIMIT_DLY: r = {1'b1, COND_LIMIT_DLY};
         `CODE_UNIVERSAL: r = {1'b1, COND_UNIVERSAL};
         `CODE_OVERHEAT: r = {1'b1, COND_OVERHEAT};
         `CODE_OUTPUT_ON: r = {1'b1, COND_OUTPUT_ON};
         `CODE_PID: r = {1'b1, COND_PID};
         `CODE_FORWARD: r = {1'b1, COND_FORWARD};
         `CODE_REVERSE: r = {1'b1, COND_REVERSE};
         `CODE_REMOTE: r = {1'b1, COND_REMOTE};
         `CODE_CI_BREAK: r = {1'b1, COND_CI_BREAK};
         `CODE_SPEED_VALID: r = {1'b1, COND_SPEED_VALID};
         `CODE_ANY_ALARM: r = {1'b1, COND_ANY_ALARM};
         default: begin
            // Contiguous ranges: alarm bits and custom outputs
            if (base >= `CODE_ALARM_B0 && base <= `CODE_ALARM_B3) begin
               r = {1'b1, 5'(COND_ALARM_B0 + 5'(base - `CODE_ALARM_B0))};
            end else if (base >= `CODE_CUSTOM_1 && base <= `CODE_CUSTOM_5) begin
               r = {1'b1, 5'(COND_CUSTOM_1 + 5'(base - `CODE_CUSTOM_1))};
            end
         end
      endcase
      return r;
   endfunction

endpackage

// ---- rtl/term_select.sv ----
/*
 One terminal stage: code decode, selection, polarity, register.
 Assumes filtered conditions synchronous to clk_i.
*/
`timescale 1ns/10ps
`include "drive_status_params.svh"

module term_select (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [drive_status_pkg::COND_N-1:0] cond_i,
   input wire drive_status_pkg::func_code_t code_i,
   output logic term_o
);
   import drive_status_pkg::*;

   logic inv; // Code is in the inverted range
   func_code_t base; // Code with the inversion offset removed
   logic [5:0] look; // {known, index}
   logic sel; // Chosen condition level

   // Split code into polarity and base function
   always_comb begin
      inv = (code_i >= `CODE_INVERT_OFS); // [R1]
      base = inv ? func_code_t'(code_i - `CODE_INVERT_OFS) : code_i;
      look = code_lookup(base);
      sel = look[5] ? cond_i[look[4:0]] : 1'b0;
   end

   // Registered terminal; polarity applied last [R24]
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         term_o <= 1'b0;
      end else if (look[5]) begin
         term_o <= sel ^ inv; // [R1] [R23]
      end else begin
         // Unknown function: inactive level [R23]
         term_o <= 1'b0;
      end
   end

endmodule

// ---- rtl/drive_status_output_select.sv ----
/*
 Drive status-output selector.
 Builds status conditions and drives three coded terminals.
 Holds the function codes in Wishbone registers.
 Assumes synchronous status inputs.
 Assumes one classic Wishbone master.
// Function
// R1 - Code picks function; plus 1000 inverts
// R2 - Codes 90-93 give alarm code bits
// R3 - Code 99: any alarm
// R4 - Codes 111-115: custom logic outputs
// R5 - Refuse unlisted inverted codes
// R6 - Running by start/stop frequency
// R7 - Output-on also in braking and standstill modes
// R8 - Vector: zero speed/servo lock assert both
// R9 - Undervoltage: bus low or trip stop
// R10 - Torque polarity high when braking
// R11 - Limiting held at least 100 ms
// R12 - Delayed limiting after 20 ms
// R13 - Keypad source output
// R14 - Ready: prepared and no alarm
// R15 - Contactor on at run, off stopped
// R16 - Universal output from software
// R17 - Overheat warning: on trip-5, off trip-8
// R18 - PID active while enabled
// R19 - Forward/reverse by running direction
// R20 - Remote mode output
// R21 - Current-loop break from comparator
// R22 - Speed valid, cleared 100 ms below
// R23 - Registered terminals; unknown code inactive
// R24 - Inversion after selection and filtering
*/
`timescale 1ns/10ps
`include "drive_status_params.svh"

module drive_status_output_select #(
   parameter int unsigned TICK_CYCLES = `CLK_HZ / `MS_PER_S // Cycles per ms
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Drive state
   input wire logic freq_above_start_i,
   input wire logic freq_below_stop_i,
   input wire logic vector_ctrl_i,
   input wire logic dc_braking_i,
   input wire logic condensation_prev_i,
   input wire logic pre_excitation_i,
   input wire logic zero_speed_ctrl_i,
   input wire logic servo_lock_i,
   input wire logic reverse_dir_i,
   input wire logic bus_below_uv_i,
   input wire logic uv_trip_stop_i,
   input wire logic torque_braking_i,
   input wire logic torque_limit_i,
   input wire logic current_limit_i,
   input wire logic hw_oc_limit_i,
   input wire logic ov_decel_limit_i,
   input wire logic keypad_source_i,
   input wire logic prep_done_i,
   input wire logic forward_run_command_i,
   input wire logic motor_stopped_i,
   input wire logic [7:0] heatsink_temp_i,
   input wire logic [7:0] heatsink_overheat_trip_i,
   input wire logic pid_enable_i,
   input wire logic remote_mode_i,
   input wire logic current_loop_input_low_i,
   input wire logic ref_above_stop_i,
   input wire logic det_above_stop_i,
   input wire logic sensorless_i,
   input wire logic alarm_active_i,
   input wire logic [3:0] alarm_code_i,
   input wire logic [4:0] custom_logic_i,
   // Output terminals
   output logic [2:0] terminals_o
);
   import drive_status_pkg::*;

   localparam int unsigned TICK_W = $clog2(TICK_CYCLES + 1);

   // Registers
   func_code_t code_reg [3]; // Code per terminal
   logic universal_reg; // Universal value
   logic refused_reg; // Refusal seen
   logic run_reg; // Running state
   logic contactor_reg; // Contactor hold
   logic overheat_reg; // Heatsink warning
   logic limit_ind_reg; // Stretched limiting
   logic [7:0] limit_hold_reg; // Hold ms left
   logic limit_dly_reg; // Delayed limiting
   logic [7:0] limit_age_reg; // Limiting ms
   logic speed_valid_reg; // Speed valid
   logic [7:0] speed_low_reg; // Low-speed ms
   logic [TICK_W-1:0] tick_cnt_reg; // Ms divider
   logic tick_reg; // Ms enable

   // Combinational helpers
   logic [COND_N-1:0] cond; // Conditions
   logic limit_any; // Any limiting
   logic speed_above; // Above stop
   logic running; // Running
   logic output_on; // Output on
   logic req; // New request
   logic wr; // Write
   logic [2:0] wr_code; // Code write
   func_code_t new_code; // Merged code
   logic new_inv; // Inverted code
   func_code_t new_base; // Base code
   logic refuse; // Refuse write
   logic refused_clr; // Flag clear
   logic [31:0] rd_data; // Read mux

   // Millisecond enable from the clock divider
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_cnt_reg <= '0;
         tick_reg <= 1'b0;
      end else if (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1)) begin
         tick_cnt_reg <= '0;
         tick_reg <= 1'b1;
      end else begin
         tick_cnt_reg <= TICK_W'(tick_cnt_reg + 1'b1);
         tick_reg <= 1'b0;
      end
   end

   // Running state: set above start, cleared below stop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_reg <= 1'b0;
      end else if (freq_above_start_i) begin
         run_reg <= 1'b1; // [R6]
      end else if (freq_below_stop_i) begin
         run_reg <= 1'b0; // [R6]
      end
   end

   // Running and output-on indications
   always_comb begin
      if (vector_ctrl_i) begin
         // Zero speed or servo lock assert both [R8]
         running = run_reg | zero_speed_ctrl_i | servo_lock_i;
         output_on = running | dc_braking_i | pre_excitation_i | condensation_prev_i;
      end else begin
         // Low in DC braking and condensation prevention [R6]
         running = run_reg & ~dc_braking_i & ~condensation_prev_i;
         // Held through braking and the rest [R7]
         output_on = run_reg | dc_braking_i | pre_excitation_i
                     | zero_speed_ctrl_i | condensation_prev_i;
      end
   end

   // Line contactor: on at run command, off once stopped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         contactor_reg <= 1'b0;
      end else if (forward_run_command_i) begin
         contactor_reg <= 1'b1; // [R15]
      end else if (motor_stopped_i) begin
         contactor_reg <= 1'b0; // [R15]
      end
   end

   // Heatsink warning with 5/8 degree hysteresis
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         overheat_reg <= 1'b0;
      end else if ({1'b0, heatsink_temp_i} + `OH_SET_MARGIN > {1'b0, heatsink_overheat_trip_i}) begin
         overheat_reg <= 1'b1; // [R17]
      end else if ({1'b0, heatsink_temp_i} + `OH_CLR_MARGIN <= {1'b0, heatsink_overheat_trip_i}) begin
         overheat_reg <= 1'b0; // [R17]
      end
   end

   // Any limiting action
   assign limit_any = torque_limit_i | current_limit_i | hw_oc_limit_i | ov_decel_limit_i;

   // Limiting indication with a minimum width
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         limit_ind_reg <= 1'b0;
         limit_hold_reg <= 8'h00;
      end else if (!limit_ind_reg && limit_any) begin
         // Rising: one extra tick covers the divider phase [R11]
         limit_ind_reg <= 1'b1;
         limit_hold_reg <= 8'(`LIMIT_MIN_MS + 8'h01);
      end else begin
         if (tick_reg && limit_hold_reg != 8'h00) begin
            limit_hold_reg <= 8'(limit_hold_reg - 8'h01);
         end
         // Drops only when hold is over and no limiting [R11]
         if (!limit_any && limit_hold_reg == 8'h00) begin
            limit_ind_reg <= 1'b0;
         end
      end
   end

   // Delayed limiting: needs continuous limiting
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         limit_dly_reg <= 1'b0;
         limit_age_reg <= 8'h00;
      end else if (!limit_any) begin
         // Any gap restarts the count [R12]
         limit_dly_reg <= 1'b0;
         limit_age_reg <= 8'h00;
      end else if (tick_reg) begin
         if (limit_age_reg > `LIMIT_DELAY_MS) begin
            limit_dly_reg <= 1'b1; // [R12]
         end else begin
            limit_age_reg <= 8'(limit_age_reg + 8'h01);
         end
      end
   end

   // Speed criterion: reference only without sensor
   assign speed_above = sensorless_i ? ref_above_stop_i : (ref_above_stop_i | det_above_stop_i); // [R22]

   // Speed valid: set at once, cleared after a low spell
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         speed_valid_reg <= 1'b0;
         speed_low_reg <= 8'h00;
      end else if (speed_above) begin
         speed_valid_reg <= 1'b1; // [R22]
         speed_low_reg <= 8'h00;
      end else if (tick_reg) begin
         if (speed_low_reg > `SPEED_HOLD_MS) begin
            speed_valid_reg <= 1'b0; // [R22]
         end else begin
            speed_low_reg <= 8'(speed_low_reg + 8'h01);
         end
      end
   end

   // Condition vector
   always_comb begin
      cond = '0;
      cond[COND_RUNNING] = running;
      cond[COND_OUTPUT_ON] = output_on;
      cond[COND_UNDERVOLT] = bus_below_uv_i | uv_trip_stop_i; // [R9]
      cond[COND_TORQUE_POL] = torque_braking_i; // [R10]
      cond[COND_LIMITING] = limit_ind_reg; // [R11]
      cond[COND_LIMIT_DLY] = limit_dly_reg; // [R12]
      cond[COND_KEYPAD] = keypad_source_i; // [R13]
      cond[COND_READY] = prep_done_i & ~alarm_active_i; // [R14]
      cond[COND_CONTACTOR] = contactor_reg; // [R15]
      cond[COND_UNIVERSAL] = universal_reg; // [R16]
      cond[COND_OVERHEAT] = overheat_reg; // [R17]
      cond[COND_PID] = pid_enable_i; // [R18]
      cond[COND_FORWARD] = running & ~reverse_dir_i; // [R19]
      cond[COND_REVERSE] = running & reverse_dir_i; // [R19]
      cond[COND_REMOTE] = remote_mode_i; // [R20]
      cond[COND_CI_BREAK] = current_loop_input_low_i; // [R21]
      cond[COND_SPEED_VALID] = speed_valid_reg; // [R22]
      cond[COND_ANY_ALARM] = alarm_active_i; // [R3]
      // Binary-weighted alarm category bits [R2]
      cond[COND_ALARM_B3:COND_ALARM_B0] = alarm_code_i;
      // Customizable logic outputs [R4]
      cond[COND_CUSTOM_5:COND_CUSTOM_1] = custom_logic_i;
   end

   // Bus request decode and write checks
   always_comb begin
      req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wr = req & wb_we_i;
      wr_code[0] = wr && (wb_adr_i == `REG_CODE_T0);
      wr_code[1] = wr && (wb_adr_i == `REG_CODE_T1);
      wr_code[2] = wr && (wb_adr_i == `REG_CODE_T2);
      new_code = code_reg[0];
      for (int i = 0; i < 3; i++) begin
         if (wr_code[i]) begin
            new_code = code_reg[i];
         end
      end
      // Merge byte lanes into the held code
      if (wb_sel_i[0]) begin
         new_code[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
         new_code[10:8] = wb_dat_i[10:8];
      end
      new_inv = (new_code >= `CODE_INVERT_OFS);
      new_base = new_inv ? func_code_t'(new_code - `CODE_INVERT_OFS) : new_code;
      // Inverted form only for functions that have one [R5]
      refuse = new_inv & ~code_lookup(new_base)[5];
      refused_clr = wr && (wb_adr_i == `REG_STATUS) && wb_sel_i[0] && wb_dat_i[`STAT_REFUSED_BIT];
   end

   // Code registers; a refused code leaves the old one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         code_reg[0] <= `RST_CODE_T0;
         code_reg[1] <= `RST_CODE_T1;
         code_reg[2] <= `RST_CODE_T2;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (wr_code[i] && !refuse) begin
               code_reg[i] <= new_code; // [R5]
            end
         end
      end
   end

   // Control register: universal output value
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         universal_reg <= 1'b0;
      end else if (wr && wb_adr_i == `REG_CONTROL && wb_sel_i[0]) begin
         universal_reg <= wb_dat_i[`CTRL_UNIVERSAL_BIT]; // [R16]
      end
   end

   // Refused flag: write one clears, a new refusal wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         refused_reg <= 1'b0;
      end else if (|wr_code && refuse) begin
         refused_reg <= 1'b1; // [R5]
      end else if (refused_clr) begin
         refused_reg <= 1'b0;
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      rd_data = 32'h0000_0000;
      case (wb_adr_i)
         `REG_CODE_T0: rd_data[10:0] = code_reg[0];
         `REG_CODE_T1: rd_data[10:0] = code_reg[1];
         `REG_CODE_T2: rd_data[10:0] = code_reg[2];
         `REG_CONTROL: rd_data[`CTRL_UNIVERSAL_BIT] = universal_reg;
         `REG_STATUS: begin
            rd_data[2:0] = terminals_o;
            rd_data[`STAT_REFUSED_BIT] = refused_reg;
         end
         `REG_CONDITIONS: rd_data[COND_N-1:0] = cond;
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // Bus answer: ack one cycle after the request, then drop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         if (req && !wb_we_i) begin
            wb_dat_o <= rd_data;
         end
      end
   end

   // Three terminal stages, registered [R23]
   for (genvar t = 0; t < 3; t++) begin : g_term
      term_select u_term (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .cond_i(cond),
         .code_i(code_reg[t]),
         .term_o(terminals_o[t])
      );
   end

endmodule

// ---- tb/drive_status_chk.sv ----
/*
 Port checker of the selector, bound to its top.
 Assumes full-lane writes to the terminal 0 code.
*/
`timescale 1ns/10ps
module drive_status_chk #(
   parameter int unsigned TICK_CYCLES = 10
) (
   input logic clk_i,
   input logic rst_i,
   input logic [7:0] wb_adr_i,
   input logic [31:0] wb_dat_i,
   input logic wb_we_i,
   input logic wb_cyc_i,
   input logic wb_stb_i,
   input logic wb_ack_o,
   input logic torque_braking_i,
   input logic alarm_active_i,
   input logic [3:0] alarm_code_i,
   input logic [4:0] custom_logic_i,
   input logic [2:0] terminals_o
);
   logic [10:0] c0_reg, c1_reg, c2_reg; // Terminal 0 code and its history
   logic [1:0] rs_reg; // Recent reset samples
   logic [31:0] hi_reg; // High run of terminal 0 under code 5
   logic [3:0] al_reg; // Alarm code one cycle back
   logic [4:0] cu_reg; // Custom outputs one cycle back
   logic [10:0] sc; // Settled code, 7FF while unsettled
   assign sc = (rs_reg == 2'b00 && c0_reg == c1_reg && c1_reg == c2_reg) ? c0_reg : 11'h7FF;
   // Shadow the code register from acknowledged writes
   always_ff @(posedge clk_i) begin
      rs_reg <= {rs_reg[0], rst_i};
      c1_reg <= c0_reg;
      c2_reg <= c1_reg;
      al_reg <= alarm_code_i;
      cu_reg <= custom_logic_i;
      hi_reg <= (sc == 11'h005 && terminals_o[0]) ? hi_reg + 32'h0000_0001 : 32'h0000_0000;
      if (rst_i) begin
         c0_reg <= 11'h000;
      end else if (wb_ack_o && wb_we_i && wb_adr_i == 8'h00) begin
         c0_reg <= wb_dat_i[10:0];
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   reset_clear_a: assert property (disable iff (1'b0) rst_i |=> terminals_o == 3'h0) else $error("reset");
   any_alarm_a: assert property (sc == 11'h063 |-> terminals_o[0] == $past(alarm_active_i))
      else $error("any alarm");
   alarm_inv_a: assert property (sc == 11'h44B |-> terminals_o[0] != $past(alarm_active_i))
      else $error("inverted alarm");
   torque_pol_a: assert property (sc == 11'h004 |-> terminals_o[0] == $past(torque_braking_i))
      else $error("torque polarity");
   alarm_bits_a: assert property (sc >= 11'h05A && sc <= 11'h05D
      |-> terminals_o[0] == al_reg[2'(sc - 11'h05A)]) else $error("alarm bit");
   custom_sel_a: assert property (sc >= 11'h06F && sc <= 11'h073
      |-> terminals_o[0] == cu_reg[3'(sc - 11'h06F)]) else $error("custom output");
   unknown_low_a: assert property (sc == 11'h001 |-> !terminals_o[0]) else $error("unknown");
   limit_hold_a: assert property (sc == 11'h005 && $fell(terminals_o[0])
      |-> hi_reg >= 100 * TICK_CYCLES) else $error("limiting too short");
   cover property (sc == 11'h005 && $fell(terminals_o[0]));
   cover property (wb_ack_o && wb_we_i);
   cover property (sc == 11'h44B && terminals_o[0]);
endmodule
bind drive_status_output_select drive_status_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clk_i, .rst_i, .wb_adr_i,
   .wb_dat_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .torque_braking_i, .alarm_active_i, .alarm_code_i,
   .custom_logic_i, .terminals_o);

// ---- tb/term_reader.sv ----
/*
 Equipment reading the three terminals.
 Assumes levels synchronous to clk_i.
*/
`timescale 1ns/10ps
module term_reader (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [2:0] terminals_i,
   output logic [2:0] level_o,
   output logic [7:0] rise0_o
);
   // Latch levels and count terminal 0 rises, catching chatter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_o <= 3'h0;
         rise0_o <= 8'h00;
      end else begin
         level_o <= terminals_i;
         rise0_o <= rise0_o + {7'h00, terminals_i[0] & ~level_o[0]};
      end
   end
endmodule

// ---- tb/drive_status_output_select_tb_top.sv ----
/*
 Selector testbench: Wishbone tasks and sequences.
 Assumes 125 MHz and ten cycles per ms tick.
*/
`timescale 1ns/10ps
module drive_status_output_select_tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic [3:0] sel = 4'h0;
   logic we = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic [31:0] s = 32'h0000_0000; // Drive state levels, one per bit
   logic [7:0] temp = 8'h00;
   logic [7:0] trip = 8'h64;
   logic [3:0] acode = 4'h0;
   logic [4:0] cust = 5'h00;
   logic [10:0] codes[10] = '{11'h003, 11'h004, 11'h008, 11'h00A, 11'h02B, 11'h036, 11'h03B, 11'h063, 11'h3EB,
      11'h44B};
   int bits[10] = '{9, 11, 16, 17, 20, 21, 22, 26, 9, 26};
   logic [7:0] tv[3] = '{8'h60, 8'h5E, 8'h5C}; // Heatsink 4, 6, 8 below trip
   wire logic [31:0] rd;
   wire logic ack;
   wire logic [2:0] term;
   wire logic [2:0] lvl;
   wire logic [7:0] rises;
   int n_mismatch = 0;
   int compares = 0;
   logic [31:0] q;
   logic [7:0] r0;
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   drive_status_output_select #(.TICK_CYCLES(10)) dut_u (
      .clk_i, .rst_i, .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rd), .wb_ack_o(ack), .freq_above_start_i(s[0]),
      .freq_below_stop_i(s[1]), .vector_ctrl_i(s[2]), .dc_braking_i(s[3]), .condensation_prev_i(s[4]),
      .pre_excitation_i(s[5]), .zero_speed_ctrl_i(s[6]), .servo_lock_i(s[7]), .reverse_dir_i(s[8]),
      .bus_below_uv_i(s[9]), .uv_trip_stop_i(s[10]), .torque_braking_i(s[11]), .torque_limit_i(s[12]),
      .current_limit_i(s[13]), .hw_oc_limit_i(s[14]), .ov_decel_limit_i(s[15]), .keypad_source_i(s[16]),
      .prep_done_i(s[17]), .forward_run_command_i(s[18]), .motor_stopped_i(s[19]), .heatsink_temp_i(temp),
      .heatsink_overheat_trip_i(trip), .pid_enable_i(s[20]), .remote_mode_i(s[21]),
      .current_loop_input_low_i(s[22]), .ref_above_stop_i(s[23]), .det_above_stop_i(s[24]),
      .sensorless_i(s[25]), .alarm_active_i(s[26]), .alarm_code_i(acode), .custom_logic_i(cust),
      .terminals_o(term));
   term_reader rd_u (.clk_i, .rst_i, .terminals_i(term), .level_o(lvl), .rise0_o(rises));
   // Compare one value, count it, report a mismatch
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One classic Wishbone cycle, held until ack is sampled
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) n_mismatch++;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0000_0000);
      chk($sformatf("register %h", a), e, q);
   endtask
   // Terminal level three cycles on
   task tchk(input int t, input logic e);
      w(3);
      chk($sformatf("terminal %0d", t), 32'(e), 32'(term[t]));
   endtask
   task w(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task setb(input int b, input logic v);
      @(posedge clk_i);
      s[b] <= v;
   endtask
   task pls(input int b);
      setb(b, 1'b1);
      setb(b, 1'b0);
   endtask
   task print_verdict();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Cut a hang short
   initial begin
      repeat (30000) @(posedge clk_i);
      n_mismatch++;
      print_verdict();
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rchk(8'h00, 32'h0000_0000);
      rchk(8'h04, 32'h0000_000A);
      rchk(8'h08, 32'h0000_0063);
      rchk(8'h20, 32'h0000_0000);
      foreach (codes[i]) begin
         wr(8'h00, {21'h00_0000, codes[i]});
         for (int v = 0; v < 2; v++) begin
            setb(bits[i], v[0]);
            tchk(0, v[0] ^ (codes[i] > 11'h3E7));
         end
         setb(bits[i], 1'b0);
      end
      wr(8'h00, 32'h0000_0001);
      tchk(0, 1'b0);
      @(posedge clk_i);
      acode <= 4'hA;
      cust <= 5'h16;
      for (int i = 0; i < 4; i++) begin
         wr(8'h00, 32'h0000_005A + i);
         tchk(0, 1'(4'hA >> i));
      end
      for (int i = 0; i < 5; i++) begin
         wr(8'h00, 32'h0000_006F + i);
         tchk(0, 1'(5'h16 >> i));
      end
      wr(8'h04, 32'h0000_03E9);
      rchk(8'h04, 32'h0000_000A);
      rchk(8'h10, 32'h0000_0009);
      wr(8'h10, 32'h0000_0008);
      rchk(8'h10, 32'h0000_0001);
      wr(8'h04, 32'h0000_0023);
      wr(8'h00, 32'h0000_0000);
      pls(0);
      tchk(0, 1'b1);
      setb(3, 1'b1);
      tchk(0, 1'b0);
      tchk(1, 1'b1);
      setb(3, 1'b0);
      wr(8'h08, 32'h0000_0035);
      setb(8, 1'b1);
      tchk(2, 1'b1);
      setb(1, 1'b1);
      tchk(0, 1'b0);
      tchk(2, 1'b0);
      setb(1, 1'b0);
      setb(2, 1'b1);
      setb(6, 1'b1);
      tchk(0, 1'b1);
      tchk(1, 1'b1);
      setb(6, 1'b0);
      setb(2, 1'b0);
      wr(8'h00, 32'h0000_001B);
      wr(8'h0C, 32'h0000_0001);
      tchk(0, 1'b1);
      rchk(8'h0C, 32'h0000_0001);
      wr(8'h00, 32'h0000_001C);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_i);
         temp <= tv[i];
         tchk(0, i < 2);
      end
      wr(8'h00, 32'h0000_000F);
      pls(18);
      tchk(0, 1'b1);
      setb(19, 1'b1);
      tchk(0, 1'b0);
      wr(8'h00, 32'h0000_0005);
      wr(8'h04, 32'h0000_0016);
      r0 = rises;
      pls(12);
      tchk(1, 1'b0);
      w(980);
      tchk(0, 1'b1);
      w(150);
      tchk(0, 1'b0);
      chk("terminal 0 rises", 32'h0000_0001, {24'h00_0000, rises - r0});
      setb(13, 1'b1);
      w(150);
      tchk(1, 1'b0);
      w(100);
      tchk(1, 1'b1);
      setb(13, 1'b0);
      tchk(1, 1'b0);
      wr(8'h00, 32'h0000_0046);
      pls(23);
      tchk(0, 1'b1);
      w(900);
      tchk(0, 1'b1);
      w(150);
      tchk(0, 1'b0);
      print_verdict();
   end
endmodule
